// File: mlf_lock_fault.sv
// Lock fault configuration register bank with lock detectors and response.
// What this block does
// - Fault register sits at 0x92 and resets to zero.
// - Overspeed detector runs only while bit 30 is set.
// - Back-EMF detector runs only while bit 29 is set.
// - Missing load detector runs only while bit 28 is set.
// - Bits 27-25 pick overspeed threshold, 130 to 200 percent of max speed.
// - Bits 24-22 pick back-EMF threshold, 40 to 70 percent.
// - Expected back-EMF is motor constant times estimated speed.
// - Lock response follows mode: latch, retry, brake, tristate or report.
// - Bits 21-19 pick missing load threshold, 1 to 20 percent.
module mlf_lock_fault #(
   parameter int unsigned RETRY_CYCLES = mlf_pkg::RETRY_CYCLES
) (
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic [15:0] est_speed,
   input  wire logic [15:0] meas_bemf,
   input  wire logic [15:0] motor_current,
   output logic             irq,
   output logic             fault_output_active_low,
   output logic             gate_tristate,
   output logic             low_side_brake
);

   logic        overspeed_lock_enable_r;
   logic        back_emf_lock_enable_r;
   logic        missing_load_lock_enable_r;
   logic [2:0]  overspeed_lock_threshold_r;
   logic [2:0]  back_emf_lock_threshold_r;
   logic [2:0]  missing_load_current_threshold_r;
   logic [3:0]  lock_response_setting_r;
   logic [15:0] motor_back_emf_constant_r;
   logic [15:0] max_speed_r;
   logic [15:0] reference_full_scale_current_r;
   logic [2:0]  irq_stat_r;
   logic [2:0]  irq_en_r;
   logic [31:0] rdata_r;
   logic [31:0] fault_word;
   logic        fault_clear;
   logic [2:0]  irq_clr;
   logic [2:0]  lock_flags;
   logic        os_flag;
   logic        bemf_flag;
   logic        ml_flag;
   logic        fault_active;
   logic        fault_output_active_low_r;
   logic [23:0] os_lhs;
   logic [23:0] os_rhs;
   logic [31:0] bemf_expected;
   logic [41:0] bemf_lhs;
   logic [41:0] bemf_rhs;
   logic [25:0] ml_lhs;
   logic [25:0] ml_rhs;

   wire wr_fault = reg_wr && reg_addr == mlf_pkg::ADDR_FAULT;
   wire wr_cfg   = reg_wr && reg_addr == mlf_pkg::ADDR_LOCK_CFG;

   // ****************************************
   // Fault configuration register
   // ****************************************
   // Reset and write.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         overspeed_lock_enable_r          <= 1'b0;
         back_emf_lock_enable_r           <= 1'b0;
         missing_load_lock_enable_r       <= 1'b0;
         overspeed_lock_threshold_r       <= mlf_pkg::THR_RESET;
         back_emf_lock_threshold_r        <= mlf_pkg::THR_RESET;
         missing_load_current_threshold_r <= mlf_pkg::THR_RESET;
      end else if (wr_fault) begin
         overspeed_lock_enable_r <= reg_wdata[mlf_pkg::OS_EN_BIT];
         back_emf_lock_enable_r  <= reg_wdata[mlf_pkg::BEMF_EN_BIT];
         missing_load_lock_enable_r <= reg_wdata[mlf_pkg::ML_EN_BIT];
         overspeed_lock_threshold_r <=
            reg_wdata[mlf_pkg::OS_THR_LSB +: mlf_pkg::THR_W];
         back_emf_lock_threshold_r <=
            reg_wdata[mlf_pkg::BEMF_THR_LSB +: mlf_pkg::THR_W];
         missing_load_current_threshold_r <=
            reg_wdata[mlf_pkg::ML_THR_LSB +: mlf_pkg::THR_W];
      end
   end

   // Reserved bit and unimplemented fields read as zero.
   always_comb begin
      fault_word = mlf_pkg::FAULT_RESET;
      fault_word[mlf_pkg::OS_EN_BIT]   = overspeed_lock_enable_r;
      fault_word[mlf_pkg::BEMF_EN_BIT] = back_emf_lock_enable_r;
      fault_word[mlf_pkg::ML_EN_BIT]   = missing_load_lock_enable_r;
      fault_word[mlf_pkg::OS_THR_LSB +: mlf_pkg::THR_W] =
         overspeed_lock_threshold_r;
      fault_word[mlf_pkg::BEMF_THR_LSB +: mlf_pkg::THR_W] =
         back_emf_lock_threshold_r;
      fault_word[mlf_pkg::ML_THR_LSB +: mlf_pkg::THR_W] =
         missing_load_current_threshold_r;
   end

   // ****************************************
   // Motor parameter and mode registers
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lock_response_setting_r        <= mlf_pkg::MODE_RESET;
         motor_back_emf_constant_r      <= mlf_pkg::HALF_RESET;
         max_speed_r                    <= mlf_pkg::HALF_RESET;
         reference_full_scale_current_r <= mlf_pkg::HALF_RESET;
      end else if (reg_wr) begin
         if (reg_addr == mlf_pkg::ADDR_LOCK_CFG) begin
            lock_response_setting_r <= reg_wdata[mlf_pkg::MODE_W-1:0];
         end
         if (reg_addr == mlf_pkg::ADDR_BEMF_K) begin
            motor_back_emf_constant_r <= reg_wdata[15:0];
         end
         if (reg_addr == mlf_pkg::ADDR_MAX_SPEED) begin
            max_speed_r <= reg_wdata[15:0];
         end
         if (reg_addr == mlf_pkg::ADDR_BASE_CUR) begin
            reference_full_scale_current_r <= reg_wdata[15:0];
         end
      end
   end

   assign fault_clear = wr_cfg && reg_wdata[mlf_pkg::FAULT_CLR_BIT];

   // ****************************************
   // Threshold arithmetic
   // ****************************************
   // Overspeed percentage of maximum speed.
   assign os_lhs = 24'(est_speed) * 24'(mlf_pkg::PCT_SCALE);
   assign os_rhs = 24'(max_speed_r)
                   * 24'(mlf_pkg::os_pct(overspeed_lock_threshold_r));
   assign bemf_expected = 32'(motor_back_emf_constant_r) * 32'(est_speed);
   assign bemf_lhs = 42'(meas_bemf) * 42'(mlf_pkg::PERMILLE_SCALE);
   assign bemf_rhs = 42'(bemf_expected)
                     * 42'(mlf_pkg::bemf_permille(back_emf_lock_threshold_r));
   assign ml_lhs = 26'(motor_current) * 26'(mlf_pkg::PERMILLE_SCALE);
   assign ml_rhs = 26'(reference_full_scale_current_r) * 26'(
      mlf_pkg::ml_permille(missing_load_current_threshold_r));

   // ****************************************
   // Detectors
   // ****************************************
   // Overspeed detector gated by its enable.
   mlf_lock_cmp #(.W(24)) u_os (
      .clk    (ref_clk),
      .rst    (rst),
      .enable (overspeed_lock_enable_r),
      .above  (1'b1),
      .lhs    (os_lhs),
      .rhs    (os_rhs),
      .flag_r (os_flag)
   );

   // Back-EMF detector gated by its enable.
   mlf_lock_cmp #(.W(42)) u_bemf (
      .clk    (ref_clk),
      .rst    (rst),
      .enable (back_emf_lock_enable_r),
      .above  (1'b0),
      .lhs    (bemf_lhs),
      .rhs    (bemf_rhs),
      .flag_r (bemf_flag)
   );

   // Missing load detector gated by its enable.
   mlf_lock_cmp #(.W(26)) u_ml (
      .clk    (ref_clk),
      .rst    (rst),
      .enable (missing_load_lock_enable_r),
      .above  (1'b0),
      .lhs    (ml_lhs),
      .rhs    (ml_rhs),
      .flag_r (ml_flag)
   );

   assign lock_flags = {ml_flag, bemf_flag, os_flag};

   // ****************************************
   // Lock response
   // ****************************************
   // Any lock feeds the response logic.
   mlf_lock_response #(.RETRY_CYCLES(RETRY_CYCLES)) u_rsp (
      .clk            (ref_clk),
      .rst            (rst),
      .lock_evt       (|lock_flags),
      .mode           (lock_response_setting_r),
      .fault_clear    (fault_clear),
      .fault_active   (fault_active),
      .gate_tristate  (gate_tristate),
      .low_side_brake (low_side_brake)
   );

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fault_output_active_low_r <= 1'b1;
      end else begin
         fault_output_active_low_r <= !fault_active;
      end
   end

   assign fault_output_active_low = fault_output_active_low_r;

   // ****************************************
   // Interrupts
   // ****************************************
   assign irq_clr = (reg_wr && reg_addr == mlf_pkg::ADDR_IRQ_CLR)
                    ? reg_wdata[2:0] : 3'h0;

   // Lock flags set sticky status, set beats clear.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_stat_r <= mlf_pkg::IRQ_RESET;
      end else begin
         irq_stat_r <= (irq_stat_r & ~irq_clr) | lock_flags;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_en_r <= mlf_pkg::IRQ_RESET;
      end else if (reg_wr && reg_addr == mlf_pkg::ADDR_IRQ_EN) begin
         irq_en_r <= reg_wdata[2:0];
      end
   end

   assign irq = |(irq_stat_r & irq_en_r);

   // ****************************************
   // Read path
   // ****************************************
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (reg_rd) begin
         unique case (reg_addr)
            mlf_pkg::ADDR_FAULT:     rdata_r <= fault_word;
            mlf_pkg::ADDR_LOCK_CFG:  rdata_r <= 32'(lock_response_setting_r);
            mlf_pkg::ADDR_BEMF_K:    rdata_r <= 32'(motor_back_emf_constant_r);
            mlf_pkg::ADDR_MAX_SPEED: rdata_r <= 32'(max_speed_r);
            mlf_pkg::ADDR_BASE_CUR:
               rdata_r <= 32'(reference_full_scale_current_r);
            mlf_pkg::ADDR_IRQ_STAT:  rdata_r <= 32'(irq_stat_r);
            mlf_pkg::ADDR_IRQ_EN:    rdata_r <= 32'(irq_en_r);
            mlf_pkg::ADDR_LOCK_STAT:
               rdata_r <= 32'({gate_tristate, low_side_brake,
                               fault_active, lock_flags});
            default:                 rdata_r <= 32'h0000_0000;
         endcase
      end else begin
         rdata_r <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_r;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   reset_zero_a: assert property (@(posedge ref_clk) disable iff (1'b0)
      rst |=> fault_word == mlf_pkg::FAULT_RESET)
      else $error("Fault register not zero after reset.");
   os_gate_a: assert property (!overspeed_lock_enable_r |=> !os_flag)
      else $error("Overspeed flag while disabled.");
   bemf_gate_a: assert property (!back_emf_lock_enable_r |=> !bemf_flag)
      else $error("Back-EMF flag while disabled.");
   ml_gate_a: assert property (!missing_load_lock_enable_r |=> !ml_flag)
      else $error("Missing load flag while disabled.");
   os_trip_a: assert property (overspeed_lock_enable_r
      && overspeed_lock_threshold_r == 3'h0
      && 32'(est_speed) * 32'd100 > 32'(max_speed_r) * 32'd130
      |=> os_flag) else $error("Overspeed not flagged at 130 percent.");
   bemf_trip_a: assert property (back_emf_lock_enable_r
      && back_emf_lock_threshold_r == 3'h6
      && 48'(meas_bemf) * 48'd1000 < 48'(bemf_expected) * 48'd675
      |=> bemf_flag) else $error("Back-EMF not flagged at 67.5 percent.");
   bemf_zero_a: assert property (
      motor_back_emf_constant_r == 16'h0000 |=> !bemf_flag)
      else $error("Back-EMF flag with zero expected value.");
   ml_trip_a: assert property (missing_load_lock_enable_r
      && missing_load_current_threshold_r == 3'h5
      && 32'(motor_current) * 32'd1000
         < 32'(reference_full_scale_current_r) * 32'd75
      |=> ml_flag) else $error("Missing load not flagged at 7.5 percent.");
   stat_sticky_a: assert property (lock_flags != 3'h0
      |=> (irq_stat_r & $past(lock_flags)) == $past(lock_flags))
      else $error("Lock flag did not set its status bit.");
   fault_output_active_low_follow_a: assert property (fault_active |=> !fault_output_active_low)
      else $error("Fault output not asserted.");

   os_c: cover property (os_flag ##1 irq);
   bemf_c: cover property (bemf_flag);
   ml_c: cover property (ml_flag ##[1:4] !fault_output_active_low);

endmodule : mlf_lock_fault

// File: mlf_pkg.sv
// Shared constants, lookup functions and types for the lock fault block.
package mlf_pkg;

   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int unsigned CLK_HZ        = 20_000_000;
   localparam int unsigned HZ_PER_MHZ    = 1_000_000;
   localparam int unsigned RETRY_TIME_US = 1000;
   localparam int unsigned RETRY_CYCLES  =
      RETRY_TIME_US * (CLK_HZ / HZ_PER_MHZ);

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_FAULT      = 8'h92;
   localparam logic [7:0] ADDR_LOCK_CFG   = 8'h94;
   localparam logic [7:0] ADDR_BEMF_K     = 8'h95;
   localparam logic [7:0] ADDR_MAX_SPEED  = 8'h96;
   localparam logic [7:0] ADDR_BASE_CUR   = 8'h97;
   localparam logic [7:0] ADDR_IRQ_STAT   = 8'h98;
   localparam logic [7:0] ADDR_IRQ_EN     = 8'h99;
   localparam logic [7:0] ADDR_IRQ_CLR    = 8'h9a;
   localparam logic [7:0] ADDR_LOCK_STAT  = 8'h9b;

   // ****************************************
   // Field layout and reset values
   // ****************************************
   localparam int unsigned OS_EN_BIT    = 30;
   localparam int unsigned BEMF_EN_BIT  = 29;
   localparam int unsigned ML_EN_BIT    = 28;
   localparam int unsigned OS_THR_LSB   = 25;
   localparam int unsigned BEMF_THR_LSB = 22;
   localparam int unsigned ML_THR_LSB   = 19;
   localparam int unsigned THR_W        = 3;
   localparam int unsigned MODE_W       = 4;
   localparam int unsigned FAULT_CLR_BIT = 4;
   localparam logic [31:0] FAULT_RESET  = 32'h0000_0000;
   localparam logic [2:0]  THR_RESET    = 3'h0;
   localparam logic [3:0]  MODE_RESET   = 4'h0;
   localparam logic [15:0] HALF_RESET   = 16'h0000;
   localparam logic [2:0]  IRQ_RESET    = 3'h0;

   // ****************************************
   // Lock response mode decode
   // ****************************************
   localparam int unsigned MODE_BRAKE_BIT = 1;
   localparam int unsigned MODE_RETRY_BIT = 2;
   localparam logic [3:0]  MODE_REPORT    = 4'h8;

   // ****************************************
   // Scales for threshold comparisons
   // ****************************************
   localparam int unsigned PCT_SCALE      = 100;
   localparam int unsigned PERMILLE_SCALE = 1000;

   typedef enum logic [2:0] {
      MLF_RSP_IDLE  = 3'b001,
      MLF_RSP_LATCH = 3'b010,
      MLF_RSP_RETRY = 3'b100
   } mlf_rsp_state_t;

   // Overspeed threshold in percent of maximum speed.
   function automatic logic [7:0] os_pct(input logic [2:0] code);
      os_pct = 8'(130 + 10 * int'(code));
   endfunction : os_pct

   // Back-EMF threshold in tenths of a percent of expected back-EMF.
   function automatic logic [9:0] bemf_permille(input logic [2:0] code);
      case (code)
         3'h0: bemf_permille = 10'h190;
         3'h1: bemf_permille = 10'h1c2;
         3'h2: bemf_permille = 10'h1f4;
         3'h3: bemf_permille = 10'h226;
         3'h4: bemf_permille = 10'h258;
         3'h5: bemf_permille = 10'h28a;
         3'h6: bemf_permille = 10'h2a3;
         default: bemf_permille = 10'h2bc;
      endcase
   endfunction : bemf_permille

   // Missing load threshold in tenths of a percent of reference_full_scale_current.
   function automatic logic [9:0] ml_permille(input logic [2:0] code);
      case (code)
         3'h0: ml_permille = 10'h00a;
         3'h1: ml_permille = 10'h014;
         3'h2: ml_permille = 10'h01e;
         3'h3: ml_permille = 10'h028;
         3'h4: ml_permille = 10'h032;
         3'h5: ml_permille = 10'h04b;
         3'h6: ml_permille = 10'h064;
         default: ml_permille = 10'h0c8;
      endcase
   endfunction : ml_permille

endpackage : mlf_pkg

// File: mlf_lock_cmp.sv
// One lock detector: a gated magnitude comparison with a registered flag.
module mlf_lock_cmp #(
   parameter int unsigned W = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         enable,
   input  wire logic         above,
   input  wire logic [W-1:0] lhs,
   input  wire logic [W-1:0] rhs,
   output logic              flag_r
);

   // ****************************************
   // Comparison
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= enable && (above ? (lhs > rhs) : (lhs < rhs));
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   cmp_disabled_a: assert property (@(posedge clk) disable iff (rst)
      !enable |=> !flag_r) else $error("Flag set while detector disabled.");

endmodule : mlf_lock_cmp

// File: mlf_lock_response.sv
// Lock response: latched, auto-retry or report-only fault handling.
module mlf_lock_response #(
   parameter int unsigned RETRY_CYCLES = mlf_pkg::RETRY_CYCLES
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       lock_evt,
   input  wire logic [3:0] mode,
   input  wire logic       fault_clear,
   output logic            fault_active,
   output logic            gate_tristate,
   output logic            low_side_brake
);

   mlf_pkg::mlf_rsp_state_t state_r;
   logic [3:0]              mode_r;
   logic [31:0]             retry_cnt_r;
   logic                    report_r;

   // ****************************************
   // State machine
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         state_r     <= mlf_pkg::MLF_RSP_IDLE;
         mode_r      <= mlf_pkg::MODE_RESET;
         retry_cnt_r <= 32'h0;
      end else begin
         unique case (state_r)
            mlf_pkg::MLF_RSP_IDLE: begin
               if (lock_evt && mode < mlf_pkg::MODE_REPORT) begin
                  mode_r <= mode;
                  if (mode[mlf_pkg::MODE_RETRY_BIT]) begin
                     state_r     <= mlf_pkg::MLF_RSP_RETRY;
                     retry_cnt_r <= 32'(RETRY_CYCLES - 1);
                  end else begin
                     state_r <= mlf_pkg::MLF_RSP_LATCH;
                  end
               end
            end
            mlf_pkg::MLF_RSP_LATCH: begin
               if (fault_clear) begin
                  state_r <= mlf_pkg::MLF_RSP_IDLE;
               end
            end
            mlf_pkg::MLF_RSP_RETRY: begin
               if (fault_clear || retry_cnt_r == 32'h0) begin
                  state_r <= mlf_pkg::MLF_RSP_IDLE;
               end else begin
                  retry_cnt_r <= retry_cnt_r - 32'h1;
               end
            end
            default: begin
               state_r <= mlf_pkg::MLF_RSP_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Report-only indication
   // ****************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         report_r <= 1'b0;
      end else begin
         report_r <= lock_evt && mode == mlf_pkg::MODE_REPORT;
      end
   end

   assign fault_active   = (state_r != mlf_pkg::MLF_RSP_IDLE) || report_r;
   assign gate_tristate  = (state_r != mlf_pkg::MLF_RSP_IDLE)
                           && !mode_r[mlf_pkg::MODE_BRAKE_BIT];
   assign low_side_brake = (state_r != mlf_pkg::MLF_RSP_IDLE)
                           && mode_r[mlf_pkg::MODE_BRAKE_BIT];

   // ****************************************
   // Checks
   // ****************************************
   brake_mode_a: assert property (@(posedge clk) disable iff (rst)
      state_r == mlf_pkg::MLF_RSP_IDLE && lock_evt && mode == 4'h2
      |=> low_side_brake && fault_active && !gate_tristate)
      else $error("Brake mode not applied on lock.");
   latch_hold_a: assert property (@(posedge clk) disable iff (rst)
      state_r == mlf_pkg::MLF_RSP_LATCH && !fault_clear
      |=> state_r == mlf_pkg::MLF_RSP_LATCH)
      else $error("Latched fault released without clear.");
   brake_c: cover property (@(posedge clk) disable iff (rst)
      low_side_brake);
   retry_c: cover property (@(posedge clk) disable iff (rst)
      state_r == mlf_pkg::MLF_RSP_RETRY ##1
      state_r == mlf_pkg::MLF_RSP_IDLE);

endmodule : mlf_lock_response

// File: mlf_lock_fault_tb.sv
// Self-checking bench for the lock fault register bank and its detectors.
module mlf_lock_fault_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned SIM_RETRY = 8;
   localparam int          TIMEOUT   = 20000;
   logic        ref_clk;
   logic        rst;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [15:0] est_speed;
   logic [15:0] meas_bemf;
   logic [15:0] motor_current;
   logic        irq;
   logic        fault_output_active_low;
   logic        gate_tristate;
   logic        low_side_brake;
   logic [31:0] v;
   int          errors;
   int          check_count;
   int          cycles;
   int unsigned lim;
   int unsigned bemf_pm [8] = '{400, 450, 500, 550, 600, 650, 675, 700};
   int unsigned ml_pm   [8] = '{10, 20, 30, 40, 50, 75, 100, 200};
   logic [3:0]  mode    [6] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'h9};
   logic [2:0]  on_exp  [6] = '{3'b100, 3'b010, 3'b100, 3'b010,
                                 3'b000, 3'b001};
   logic        off_flt [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

   mlf_lock_fault #(.RETRY_CYCLES(SIM_RETRY)) dut (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .est_speed(est_speed),
      .meas_bemf(meas_bemf), .motor_current(motor_current), .irq(irq),
      .fault_output_active_low(fault_output_active_low),
      .gate_tristate(gate_tristate), .low_side_brake(low_side_brake));

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr    <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd   <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic drive(input int d, input logic [15:0] x, input int n);
      @(posedge ref_clk);
      est_speed     <= (d == 0) ? x : 16'h0064;
      meas_bemf     <= (d == 1) ? x : 16'h03e8;
      motor_current <= (d == 2) ? x : 16'h03e8;
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : drive

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT) begin
         errors++;
         complete_run();
      end
   end

   initial begin
      {rst, reg_wr, reg_rd} = 3'b100;
      {reg_addr, reg_wdata, est_speed, meas_bemf, motor_current} = '0;
      {errors, check_count, cycles} = '0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rd(mlf_pkg::ADDR_FAULT);
      check("fault reg reset", v, mlf_pkg::FAULT_RESET);
      check("fault pin idle", {31'h0, fault_output_active_low}, 32'h1);
      rd(8'h00);
      check("unmapped read", v, 32'h0);
      wr(mlf_pkg::ADDR_FAULT, 32'hffff_ffff);
      rd(mlf_pkg::ADDR_FAULT);
      check("fault reg ones", v, 32'h7ff8_0000);
      rd(mlf_pkg::ADDR_IRQ_CLR);
      check("clear reg read", v, 32'h0);
      $display("test register access done");
      wr(mlf_pkg::ADDR_LOCK_CFG, 32'h9);
      wr(mlf_pkg::ADDR_MAX_SPEED, 32'd100);
      wr(mlf_pkg::ADDR_BEMF_K, 32'd2);
      wr(mlf_pkg::ADDR_BASE_CUR, 32'd1000);
      rd(mlf_pkg::ADDR_MAX_SPEED);
      check("max speed read", v, 32'h64);
      rd(mlf_pkg::ADDR_LOCK_CFG);
      check("mode read", v, 32'h9);
      for (int d = 0; d < 3; d++) begin
         for (int c = 0; c < 8; c++) begin
            lim = (d == 0) ? 130 + 10 * c
                : (d == 1) ? bemf_pm[c] / 5 : ml_pm[c];
            wr(mlf_pkg::ADDR_FAULT, 32'(c) << (25 - 3 * d));
            drive(d, 16'((d == 0) ? lim + 1 : lim - 1), 3);
            rd(mlf_pkg::ADDR_LOCK_STAT);
            check("flag disabled", {31'h0, v[d]}, 32'h0);
            wr(mlf_pkg::ADDR_FAULT,
               (32'(c) << (25 - 3 * d)) | (32'h1 << (30 - d)));
            repeat (3) @(posedge ref_clk);
            rd(mlf_pkg::ADDR_LOCK_STAT);
            check("flag over", {31'h0, v[d]}, 32'h1);
            drive(d, 16'(lim), 3);
            rd(mlf_pkg::ADDR_LOCK_STAT);
            check("flag equal", {31'h0, v[d]}, 32'h0);
         end
      end
      $display("test detector thresholds done");
      wr(mlf_pkg::ADDR_FAULT, 32'h4000_0000);
      for (int m = 0; m < 6; m++) begin
         wr(mlf_pkg::ADDR_LOCK_CFG, 32'(mode[m]));
         drive(0, 16'd200, 5);
         check("response on lock", {29'h0, gate_tristate, low_side_brake,
               fault_output_active_low}, 32'(on_exp[m]));
         drive(0, 16'd0, 30);
         check("fault after lock", {31'h0, fault_output_active_low},
               32'(off_flt[m]));
         wr(mlf_pkg::ADDR_LOCK_CFG, 32'h10 | 32'(mode[m]));
         repeat (3) @(posedge ref_clk);
         #1;
         check("fault cleared", {29'h0, gate_tristate, low_side_brake,
               fault_output_active_low}, 32'h1);
      end
      $display("test lock response done");
      wr(mlf_pkg::ADDR_IRQ_EN, 32'h1);
      wr(mlf_pkg::ADDR_IRQ_CLR, 32'h7);
      drive(0, 16'd200, 4);
      check("irq raised", {31'h0, irq}, 32'h1);
      drive(0, 16'd0, 3);
      rd(mlf_pkg::ADDR_IRQ_STAT);
      check("status sticky", v, 32'h1);
      wr(mlf_pkg::ADDR_IRQ_CLR, 32'h1);
      rd(mlf_pkg::ADDR_IRQ_STAT);
      check("status cleared", v, 32'h0);
      check("irq dropped", {31'h0, irq}, 32'h0);
      wr(mlf_pkg::ADDR_IRQ_EN, 32'h0);
      drive(0, 16'd200, 4);
      check("irq masked", {31'h0, irq}, 32'h0);
      rd(mlf_pkg::ADDR_IRQ_STAT);
      check("status masked", v, 32'h1);
      $display("test interrupt done");
      complete_run();
   end
endmodule : mlf_lock_fault_tb
